// File: design/arb_block_pkg.sv
package arb_block_pkg;

    // Character codes seen in the block stream
    localparam logic [7:0] CHAR_HASH     = 8'h23;
    localparam logic [7:0] CHAR_ZERO     = 8'h30;
    localparam logic [7:0] CHAR_NINE     = 8'h39;
    localparam logic [7:0] CHAR_LF       = 8'h0A;
    localparam logic [7:0] CHAR_CR       = 8'h0D;

    // Sample span and baseline
    localparam logic signed [15:0] SAMPLE_MAX  = 16'sh1FFF;
    localparam logic signed [15:0] SAMPLE_MIN  = -16'sh1FFF;
    localparam logic [15:0]        SAMPLE_ZERO = 16'h0000;

    // Largest count of length digits the parser accepts
    localparam int unsigned MAX_LEN_DIGITS = 9;

    // Error codes pushed to the error queue
    typedef enum logic [2:0] {
        ERR_NONE      = 3'b000,
        ERR_PREAMBLE  = 3'b001,
        ERR_ODD_COUNT = 3'b010,
        ERR_SHORT     = 3'b011,
        ERR_RANGE     = 3'b100,
        ERR_ODD_TERM  = 3'b101
    } err_code_t;

    // Parser states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_NDIG   = 3'b001,
        ST_COUNT  = 3'b010,
        ST_DEF    = 3'b011,
        ST_INDEF  = 3'b100,
        ST_SKIP   = 3'b101
    } parse_state_t;

    // One received byte from the bus acceptor
    typedef struct packed {
        logic [7:0] data;
        logic       eoi;
    } rx_byte_t;

    // One assembled sample
    typedef struct packed {
        logic signed [15:0] value;
        logic               last;
    } sample_t;

    // One binary readback byte
    typedef struct packed {
        logic [7:0] data;
        logic       eoi;
    } tx_byte_t;

endpackage

// File: design/arb_sample_pack.sv
`timescale 1ns/1ps

// Pairs payload bytes into samples, high byte first
module arb_sample_pack (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     ce,
    input  wire logic                     clear,
    input  wire logic                     byte_valid,
    input  wire logic [7:0]               byte_data,
    input  wire logic                     byte_last,
    output logic                          half,
    output logic                          smp_valid,
    output arb_block_pkg::sample_t        smp
);
    logic                   next_half;
    logic [7:0]             high_byte;
    logic [7:0]             next_high_byte;
    logic                   next_smp_valid;
    arb_block_pkg::sample_t next_smp;

    // Hold the first byte, emit on the second
    always_comb begin
        next_half      = half;
        next_high_byte = high_byte;
        next_smp_valid = 1'b0;
        next_smp       = smp;
        if (clear) begin
            next_half = 1'b0;
        end else if (byte_valid) begin
            if (!half) begin
                next_high_byte = byte_data;
                next_half      = 1'b1;
            end else begin
                next_smp.value = {high_byte, byte_data};
                next_smp.last  = byte_last;
                next_smp_valid = 1'b1;
                next_half      = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            half      <= 1'b0;
            high_byte <= 8'h00;
            smp_valid <= 1'b0;
            smp       <= '0;
        end else if (ce) begin
            half      <= next_half;
            high_byte <= next_high_byte;
            smp_valid <= next_smp_valid;
            smp       <= next_smp;
        end
    end

endmodule // arb_sample_pack

// File: design/arb_block_data_receiver.sv
`timescale 1ns/1ps

module arb_block_data_receiver #(
    parameter int unsigned COUNT_W = 32
) (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     ce,
    input  wire logic                     device_clear,
    input  wire logic                     header_seen,
    input  wire logic                     rx_valid,
    input  wire arb_block_pkg::rx_byte_t  rx,
    input  wire logic                     rd_start,
    input  wire logic                     rd_valid,
    input  wire logic [15:0]              rd_sample,
    input  wire logic                     rd_last,
    input  wire logic                     tx_ready,
    output logic                          rd_ready,
    output logic                          tx_valid,
    output arb_block_pkg::tx_byte_t       tx,
    output logic                          smp_valid,
    output arb_block_pkg::sample_t        smp,
    output logic                          busy,
    output logic                          err_push,
    output arb_block_pkg::err_code_t      err_code
);
    // Refuse counter widths the decimal accumulate cannot serve
    if (COUNT_W < 8 || COUNT_W > 32) begin : g_bad_count_w
        $error("COUNT_W must lie in 8..32");
    end

    arb_block_pkg::parse_state_t state;
    arb_block_pkg::parse_state_t next_state;
    logic [3:0]              digits;
    logic [3:0]              next_digits;
    logic [COUNT_W-1:0]      remain;
    logic [COUNT_W-1:0]      next_remain;
    logic                    next_busy;
    logic                    next_err_push;
    arb_block_pkg::err_code_t next_err_code;
    logic                    pay_valid;
    logic                    pay_last;
    logic                    half;
    logic                    is_digit;
    logic [3:0]              digit_val;
    logic [COUNT_W-1:0]      scaled;

    assign is_digit  = rx.data >= arb_block_pkg::CHAR_ZERO &&
                       rx.data <= arb_block_pkg::CHAR_NINE;
    assign digit_val = 4'(rx.data - arb_block_pkg::CHAR_ZERO);
    // Decimal accumulate; top bits wrap only past COUNT_W
    assign scaled    = COUNT_W'((remain << 3) + (remain << 1) +
                                COUNT_W'(digit_val));

    // Parser: preamble decode, payload gating, error report
    always_comb begin
        next_state    = state;
        next_digits   = digits;
        next_remain   = remain;
        next_err_push = 1'b0;
        next_err_code = err_code;
        pay_valid     = 1'b0;
        pay_last      = 1'b0;
        if (device_clear) begin
            next_state = arb_block_pkg::ST_IDLE;
        end else if (rx_valid) begin
            case (state)
                arb_block_pkg::ST_IDLE: begin
                    // Wait for header, then the block mark
                    if (header_seen &&
                        rx.data == arb_block_pkg::CHAR_HASH) begin
                        next_state = arb_block_pkg::ST_NDIG;
                    end
                end
                arb_block_pkg::ST_NDIG: begin
                    next_remain = '0;
                    if (rx.data == arb_block_pkg::CHAR_ZERO) begin
                        next_state = arb_block_pkg::ST_INDEF;
                    end else if (is_digit) begin
                        next_digits = digit_val;
                        next_state  = arb_block_pkg::ST_COUNT;
                    end else begin
                        next_err_push = 1'b1;
                        next_err_code = arb_block_pkg::ERR_PREAMBLE;
                        next_state    = arb_block_pkg::ST_SKIP;
                    end
                end
                arb_block_pkg::ST_COUNT: begin
                    if (!is_digit) begin
                        next_err_push = 1'b1;
                        next_err_code = arb_block_pkg::ERR_PREAMBLE;
                        next_state    = arb_block_pkg::ST_SKIP;
                    end else begin
                        next_remain = scaled;
                        next_digits = 4'(digits - 4'h1);
                        if (digits == 4'h1) begin
                            if (scaled[0]) begin
                                next_err_push = 1'b1;
                                next_err_code =
                                    arb_block_pkg::ERR_ODD_COUNT;
                                next_state = arb_block_pkg::ST_SKIP;
                            end else if (scaled == '0) begin
                                next_state = arb_block_pkg::ST_IDLE;
                            end else begin
                                next_state = arb_block_pkg::ST_DEF;
                            end
                        end
                    end
                end
                arb_block_pkg::ST_DEF: begin
                    pay_valid   = 1'b1;
                    next_remain = COUNT_W'(remain - 1'b1);
                    if (remain == COUNT_W'(1)) begin
                        pay_last   = 1'b1;
                        next_state = arb_block_pkg::ST_IDLE;
                    end else if (rx.eoi) begin
                        // Bus message ended before the count ran out
                        next_err_push = 1'b1;
                        next_err_code = arb_block_pkg::ERR_SHORT;
                        next_state    = arb_block_pkg::ST_IDLE;
                    end
                end
                arb_block_pkg::ST_INDEF: begin
                    // LF with EOI ends it on a sample boundary; any EOI mid sample ends it with an error
                    if (rx.eoi && !half &&
                        rx.data == arb_block_pkg::CHAR_LF) begin
                        next_state = arb_block_pkg::ST_IDLE;
                    end else if (rx.eoi && half) begin
                        pay_valid     = 1'b1;
                        pay_last      = 1'b1;
                        next_err_push = 1'b1;
                        next_err_code = arb_block_pkg::ERR_ODD_TERM;
                        next_state    = arb_block_pkg::ST_IDLE;
                    end else begin
                        pay_valid = 1'b1;
                    end
                end
                arb_block_pkg::ST_SKIP: begin
                    // Drop the rest of a broken message
                    if (rx.eoi) begin
                        next_state = arb_block_pkg::ST_IDLE;
                    end
                end
                default: next_state = arb_block_pkg::ST_IDLE;
            endcase
        end
        next_busy = next_state != arb_block_pkg::ST_IDLE;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state    <= arb_block_pkg::ST_IDLE;
            digits   <= 4'h0;
            remain   <= '0;
            busy     <= 1'b0;
            err_push <= 1'b0;
            err_code <= arb_block_pkg::ERR_NONE;
        end else if (ce) begin
            state    <= next_state;
            digits   <= next_digits;
            remain   <= next_remain;
            busy     <= next_busy;
            err_push <= next_err_push;
            err_code <= next_err_code;
        end
    end

    arb_sample_pack u_pack (
        .clk        (clk),
        .resetn     (resetn),
        .ce         (ce),
        .clear      (device_clear || state == arb_block_pkg::ST_IDLE),
        .byte_valid (pay_valid),
        .byte_data  (rx.data),
        .byte_last  (pay_last),
        .half       (half),
        .smp_valid  (smp_valid),
        .smp        (smp)
    );

    // Readback framer: "#0", sample bytes, LF with EOI
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_HASH = 3'b001,
        TX_ZERO = 3'b010,
        TX_HIGH = 3'b011,
        TX_LOW  = 3'b100,
        TX_TERM = 3'b101
    } tx_state_t;

    tx_state_t           tstate;
    tx_state_t           next_tstate;
    logic [15:0]         hold;
    logic [15:0]         next_hold;
    logic                hold_last;
    logic                next_hold_last;
    logic                next_tx_valid;
    logic                next_rd_ready;
    arb_block_pkg::tx_byte_t next_tx;

    // One byte in flight; a new one loads once the last is taken
    always_comb begin
        next_tstate    = tstate;
        next_hold      = hold;
        next_hold_last = hold_last;
        next_tx_valid  = tx_valid && !tx_ready;
        next_tx        = tx;
        next_rd_ready  = 1'b0;
        if (device_clear) begin
            next_tstate   = TX_IDLE;
            next_tx_valid = 1'b0;
        end else if (!next_tx_valid) begin
            case (tstate)
                TX_IDLE: begin
                    if (rd_start) begin
                        next_tstate = TX_HASH;
                    end
                end
                TX_HASH: begin
                    next_tx_valid = 1'b1;
                    next_tx       = '{arb_block_pkg::CHAR_HASH, 1'b0};
                    next_tstate   = TX_ZERO;
                end
                TX_ZERO: begin
                    next_tx_valid = 1'b1;
                    next_tx       = '{arb_block_pkg::CHAR_ZERO, 1'b0};
                    next_tstate   = TX_HIGH;
                end
                TX_HIGH: begin
                    next_rd_ready = !rd_ready;
                    if (rd_ready && rd_valid) begin
                        next_hold      = rd_sample;
                        next_hold_last = rd_last;
                        next_tx_valid  = 1'b1;
                        next_tx        = '{rd_sample[15:8], 1'b0};
                        next_tstate    = TX_LOW;
                        next_rd_ready  = 1'b0;
                    end
                end
                TX_LOW: begin
                    next_tx_valid = 1'b1;
                    next_tx       = '{hold[7:0], 1'b0};
                    next_tstate   = hold_last ? TX_TERM : TX_HIGH;
                end
                TX_TERM: begin
                    next_tx_valid = 1'b1;
                    next_tx       = '{arb_block_pkg::CHAR_LF, 1'b1};
                    next_tstate   = TX_IDLE;
                end
                default: next_tstate = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tstate    <= TX_IDLE;
            hold      <= 16'h0000;
            hold_last <= 1'b0;
            tx_valid  <= 1'b0;
            tx        <= '0;
            rd_ready  <= 1'b0;
        end else if (ce) begin
            tstate    <= next_tstate;
            hold      <= next_hold;
            hold_last <= next_hold_last;
            tx_valid  <= next_tx_valid;
            tx        <= next_tx;
            rd_ready  <= next_rd_ready;
        end
    end

endmodule // arb_block_data_receiver

// File: sim/arb_host_model.sv
`timescale 1ns/1ps

// Remote controller: sends block bytes, sinks binary readback
module arb_host_model (
    input  wire logic                    clk,
    input  wire logic                    stall_en,
    input  wire logic                    tx_valid,
    input  wire arb_block_pkg::tx_byte_t tx,
    output logic                         rx_valid,
    output arb_block_pkg::rx_byte_t      rx,
    output logic                         tx_ready
);
    logic [8:0] got[$];

    // Quiet bus at time zero
    initial begin
        rx_valid = 1'b0;
        rx = '0;
        tx_ready = 1'b0;
    end

    // One byte held over exactly one edge, so bytes run back to back
    task automatic send(input logic [7:0] d, input logic e);
        @(posedge clk);
        #1;
        rx_valid = 1'b1;
        rx = {d, e};
    endtask

    // Released lines flip, so a stale byte never looks valid
    task automatic release_bus();
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx = ~rx;
    endtask

    // Readback sink; random stalls mimic a slow listener
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx);
        tx_ready <= !stall_en || ($urandom % 3 == 0);
    end
endmodule // arb_host_model

// File: sim/arb_block_data_receiver_asserts.sv
`timescale 1ns/1ps

// Port-level checks for the block receiver
module arb_block_data_receiver_asserts #(
    parameter int unsigned COUNT_W = 32
) (
    input wire logic                     clk,
    input wire logic                     resetn,
    input wire logic                     ce,
    input wire logic                     device_clear,
    input wire logic                     header_seen,
    input wire logic                     rx_valid,
    input wire arb_block_pkg::rx_byte_t  rx,
    input wire logic                     rd_start,
    input wire logic                     tx_ready,
    input wire logic                     rd_ready,
    input wire logic                     tx_valid,
    input wire arb_block_pkg::tx_byte_t  tx,
    input wire logic                     smp_valid,
    input wire logic                     busy,
    input wire logic                     err_push,
    input wire arb_block_pkg::err_code_t err_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Strobes last one enabled edge and follow a taken byte
    AST_SMP_PULSE: assert property (smp_valid && ce |=> !smp_valid)
        else $error("sample strobe too long");
    AST_SMP_CAUSE: assert property (
        $rose(smp_valid) |-> $past(ce && rx_valid))
        else $error("sample without a byte");
    AST_ERR_CAUSE: assert property ($rose(err_push) |->
        $past(ce && rx_valid) && err_code != arb_block_pkg::ERR_NONE)
        else $error("bad error push");

    // Clear drops everything within one edge
    AST_CLEAR_IDLE: assert property (ce && device_clear |=>
        !busy && !tx_valid)
        else $error("clear did not idle");

    // Heralded mark opens a block
    AST_HASH_BUSY: assert property (
        ce && rx_valid && header_seen && !busy && !device_clear &&
        rx.data == arb_block_pkg::CHAR_HASH |-> ##[1:2] busy)
        else $error("mark not taken");

    // Readback byte waits for the listener
    AST_TX_HOLD: assert property (
        tx_valid && !tx_ready && !device_clear |=> tx_valid && $stable(tx))
        else $error("readback byte dropped");
    AST_TX_EOI: assert property (tx_valid && tx.eoi |->
        tx.data == arb_block_pkg::CHAR_LF)
        else $error("end mark not on line feed");
    AST_RB_HASH: assert property (
        ce && rd_start && !busy && !tx_valid && !rd_ready && !device_clear
        ##1 ce && !device_clear |=>
        tx_valid && tx.data == arb_block_pkg::CHAR_HASH)
        else $error("readback frame not opened");
endmodule // arb_block_data_receiver_asserts

bind arb_block_data_receiver arb_block_data_receiver_asserts #(
    .COUNT_W(COUNT_W)
) i_asserts (
    .clk(clk), .resetn(resetn), .ce(ce), .device_clear(device_clear),
    .header_seen(header_seen), .rx_valid(rx_valid), .rx(rx),
    .rd_start(rd_start), .tx_ready(tx_ready), .rd_ready(rd_ready),
    .tx_valid(tx_valid), .tx(tx), .smp_valid(smp_valid), .busy(busy),
    .err_push(err_push), .err_code(err_code)
);

// File: sim/test_arb_block_data_receiver.sv
`timescale 1ns/1ps

`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            fails++; \
            $display("mismatch %s exp %h got %h", what, exp, got); \
        end \
    end

module test_arb_block_data_receiver;
    logic                     clk = 1'b0;
    logic                     resetn = 1'b0;
    logic                     ce = 1'b1;
    logic                     device_clear = 1'b0;
    logic                     header_seen = 1'b1;
    logic                     rd_start = 1'b0;
    logic                     stall_en = 1'b0;
    logic                     rx_valid, tx_ready, rd_ready, tx_valid;
    logic                     smp_valid, busy, err_push, rd_valid, rd_last;
    logic [15:0]              rd_sample;
    logic [15:0]              odd_v;
    logic [15:0]              rd_mem[0:15];
    arb_block_pkg::rx_byte_t  rx;
    arb_block_pkg::tx_byte_t  tx;
    arb_block_pkg::sample_t   smp;
    arb_block_pkg::err_code_t err_code;
    logic [16:0]              ex_s[$];
    logic [2:0]               ex_e[$];
    logic [8:0]               ex_t[$];
    logic [16:0]              es;
    logic [2:0]               ee;
    int                       fails = 0;
    int                       n_compared = 0;
    int                       rd_n = 0;
    int                       rd_idx = 0;

    always #2 clk = ~clk;

    // Waveform memory feeding the readback path
    assign rd_valid = rd_idx < rd_n;
    assign rd_last = rd_idx == rd_n - 1;
    assign rd_sample = rd_mem[rd_idx[3:0]];
    always @(posedge clk)
        if (ce && rd_ready && rd_valid)
            rd_idx <= rd_idx + 1;

    arb_block_data_receiver #(.COUNT_W(16)) i_arb_block_data_receiver (
        .clk(clk), .resetn(resetn), .ce(ce), .device_clear(device_clear),
        .header_seen(header_seen), .rx_valid(rx_valid), .rx(rx),
        .rd_start(rd_start), .rd_valid(rd_valid), .rd_sample(rd_sample),
        .rd_last(rd_last), .tx_ready(tx_ready), .rd_ready(rd_ready),
        .tx_valid(tx_valid), .tx(tx), .smp_valid(smp_valid), .smp(smp),
        .busy(busy), .err_push(err_push), .err_code(err_code)
    );

    arb_host_model i_arb_host_model (
        .clk(clk), .stall_en(stall_en), .tx_valid(tx_valid), .tx(tx),
        .rx_valid(rx_valid), .rx(rx), .tx_ready(tx_ready)
    );

    // Each strobe meets the model's next entry; extras meet an unknown
    always @(negedge clk) begin
        if (smp_valid === 1'b1 && ce) begin
            es = ex_s.size() ? ex_s.pop_front() : 'x;
            `CHK("sample", es, smp)
        end
        if (err_push === 1'b1 && ce) begin
            ee = ex_e.size() ? ex_e.pop_front() : 'x;
            `CHK("error code", ee, err_code)
        end
    end

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic put(input logic [7:0] d, input logic e = 1'b0);
        i_arb_host_model.send(d, e);
    endtask

    // Even payload of random samples inside the span, optional freezes
    task automatic payload(input int n, input logic cnt, input logic frz);
        logic [15:0] v;
        for (int i = 0; i < n / 2; i++) begin
            v = 16'($urandom_range(16382)) - 16'h1FFF;
            put(v[15:8]);
            if (frz) begin
                i_arb_host_model.release_bus();
                ce = 1'b0;
                repeat (2) @(posedge clk);
                #1 ce = 1'b1;
            end
            put(v[7:0]);
            ex_s.push_back({v, cnt && i == n / 2 - 1});
        end
    endtask

    // Counted form: digit count, decimal length, payload
    task automatic counted(input int n, input logic frz = 1'b0);
        put(arb_block_pkg::CHAR_HASH);
        put(n > 9 ? 8'h32 : 8'h31);
        if (n > 9)
            put(arb_block_pkg::CHAR_ZERO + 8'(n / 10));
        put(arb_block_pkg::CHAR_ZERO + 8'(n % 10));
        payload(n, 1'b1, frz);
    endtask

    // Waits are bounded; a lost strobe ends the run
    task automatic settle(input string name);
        int k;
        i_arb_host_model.release_bus();
        for (k = 0; k < 300; k++) begin
            @(negedge clk);
            if (busy === 1'b0 && ex_s.size() == 0 && ex_e.size() == 0)
                break;
        end
        if (k == 300) begin
            fails++;
            $display("mismatch %s exp idle got busy", name);
            wrap_up();
        end
        repeat (3) @(negedge clk);
        `CHK("busy", 1'b0, busy)
        $display("test %s done", name);
    endtask

    // Main sequence
    initial begin
        void'($urandom(19));
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        header_seen = 1'b0;
        put(arb_block_pkg::CHAR_HASH);
        put(8'h31);
        header_seen = 1'b1;
        put(8'h55);
        put(arb_block_pkg::CHAR_HASH);
        put(8'h31);
        put(arb_block_pkg::CHAR_ZERO);
        settle("idle");
        for (int i = 0; i < 8; i++) begin
            counted(i < 2 ? 2 + 8 * i : 2 * $urandom_range(1, 24));
            settle("counted");
        end
        for (int i = 0; i < 4; i++) begin
            put(arb_block_pkg::CHAR_HASH);
            put(arb_block_pkg::CHAR_ZERO);
            payload(2 * $urandom_range(1, 12), 1'b0, 1'b0);
            put(arb_block_pkg::CHAR_LF, 1'b1);
            settle("uncounted");
        end
        // End mark on a low byte: sample kept as last, error logged
        odd_v = 16'($urandom);
        ex_e.push_back(arb_block_pkg::ERR_ODD_TERM);
        ex_s.push_back({odd_v, 1'b1});
        put(arb_block_pkg::CHAR_HASH);
        put(arb_block_pkg::CHAR_ZERO);
        put(odd_v[15:8]);
        put(odd_v[7:0], 1'b1);
        settle("odd end");
        counted(6, 1'b1);
        settle("freeze");
        // Malformed blocks: odd count, early end, bad digit count
        ex_e.push_back(arb_block_pkg::ERR_ODD_COUNT);
        put(arb_block_pkg::CHAR_HASH);
        put(8'h31);
        put(8'h33);
        put(8'h11);
        put(8'h22, 1'b1);
        settle("odd count");
        ex_e.push_back(arb_block_pkg::ERR_SHORT);
        put(arb_block_pkg::CHAR_HASH);
        put(8'h31);
        put(8'h34);
        put(8'h11, 1'b1);
        settle("short");
        ex_e.push_back(arb_block_pkg::ERR_PREAMBLE);
        put(arb_block_pkg::CHAR_HASH);
        put(8'h41);
        put(8'h22, 1'b1);
        settle("preamble");
        // Clear in mid payload leaves no half sample behind
        put(arb_block_pkg::CHAR_HASH);
        put(8'h31);
        put(8'h38);
        put(8'h7E);
        i_arb_host_model.release_bus();
        device_clear = 1'b1;
        @(posedge clk);
        #1 device_clear = 1'b0;
        counted(4);
        settle("clear");
        // Binary readback under a stalling listener
        ex_t.push_back({arb_block_pkg::CHAR_HASH, 1'b0});
        ex_t.push_back({arb_block_pkg::CHAR_ZERO, 1'b0});
        for (int i = 0; i < 3; i++) begin
            rd_mem[i] = 16'($urandom);
            ex_t.push_back({rd_mem[i][15:8], 1'b0});
            ex_t.push_back({rd_mem[i][7:0], 1'b0});
        end
        ex_t.push_back({arb_block_pkg::CHAR_LF, 1'b1});
        rd_n = 3;
        stall_en = 1'b1;
        @(posedge clk);
        #1 rd_start = 1'b1;
        @(posedge clk);
        #1 rd_start = 1'b0;
        for (int k = 0; k < 300 && i_arb_host_model.got.size() < 9; k++)
            @(negedge clk);
        // A frame that never completes is counted here
        `CHK("readback count", 9, i_arb_host_model.got.size())
        foreach (ex_t[i])
            `CHK("readback", ex_t[i], i_arb_host_model.got[i])
        settle("readback");
        wrap_up();
    end
endmodule // test_arb_block_data_receiver
